// ==== verilog/event_action_pkg.sv ====
/*
 Shared constants and types of the event monitor and action dispatcher.
 Assumes a 20 MHz system clock; action codes are two BCD digits.
*/
`default_nettype none
package event_action_pkg;
   localparam int CLK_HZ = 20_000_000;
   localparam int NUM_EVENTS = 35;
   localparam int EVT_W = 6;
   localparam int CNT_W = 14;
   localparam logic [CNT_W-1:0] CNT_MAX = 14'h270F;
   localparam logic [CNT_W-1:0] CNT_RESET = 14'h0000;
   localparam int ACT_PER_LIST = 5;
   localparam int NUM_LEVELS = 3;
   localparam int SAMPLE_S = 6;
   localparam int SAMPLE_CYCLES = SAMPLE_S * CLK_HZ;
   localparam int BUTTON_MS = 3500;
   localparam int BUTTON_CYCLES = BUTTON_MS * (CLK_HZ / 1000);
   localparam int SEC_CYCLES = CLK_HZ;
   localparam int RECHECK_UNIT_S = 60;
   localparam logic [EVT_W-1:0] BUS_RESET_EVT = 6'h08;
   localparam logic [EVT_W-1:0] APP_FIRST_EVT = 6'h0D;
   localparam logic [EVT_W-1:0] APP_LAST_EVT = 6'h1C;
   localparam logic [7:0] ACT_NOP = 8'h00;
   localparam logic [7:0] ACT_SPEAKER = 8'h10;
   localparam logic [7:0] ACT_CLOSE_ALL = 8'h34;
   localparam logic [7:0] ACT_OPEN_ALL = 8'h44;
   localparam logic [7:0] ACT_MODEM_INIT = 8'h50;
   localparam logic [7:0] ACT_PANIC1 = 8'h51;
   localparam logic [7:0] ACT_PANIC2 = 8'h52;
   localparam logic [7:0] ACT_PANIC_LOG = 8'h53;
   localparam logic [7:0] ACT_CNT_CLEAR = 8'h60;
   localparam logic [7:0] ACT_LOG_EVENT = 8'h70;
   localparam logic [7:0] ACT_STANDALONE = 8'h89;
   localparam logic [7:0] ACT_HOST_RESET = 8'h99;
   typedef enum logic [1:0]
   {
      DISP_IDLE = 2'b00,
      DISP_FETCH = 2'b01,
      DISP_RUN = 2'b10,
      DISP_WAIT = 2'b11
   } disp_state_type;
endpackage
`default_nettype wire

// ==== verilog/action_if.sv ====
/*
 Action request carrier between the monitor core and the action dispatcher.
 Assumes one clock; req is held until ack.
*/
`timescale 1ns/100ps
`default_nettype none
interface action_if;
   import event_action_pkg::*;
   logic req;
   logic ack;
   logic [EVT_W-1:0] evt;
   logic [1:0] level;
   logic [CNT_W-1:0] count;
   logic [8*ACT_PER_LIST-1:0] actions;
   logic cnt_clear;
   modport core (output req, evt, level, count, actions, input ack, cnt_clear);
   modport disp (input req, evt, level, count, actions, output ack, cnt_clear);
endinterface
`default_nettype wire

// ==== verilog/action_dispatch.sv ====
/*
 Walks one five-code action list in order and drives the action outputs; a code 11-19 in fourth place ends the walk, one in fifth runs it past the list.
 Assumes the list is stable while req is high.
*/
`timescale 1ns/100ps
`default_nettype none
module action_dispatch
   import event_action_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   action_if.disp act,
   output logic [3:0] contact,
   output logic speaker,
   output logic console_req,
   output logic [3:0] console_crlf,
   output logic modem_init,
   output logic panic_call1,
   output logic panic_call2,
   output logic panic_log,
   output logic event_log,
   output logic standalone,
   output logic host_reset,
   output logic [3:0] recheck_min,
   output logic recheck_req
);
   typedef struct packed
   {
      disp_state_type st;
      logic [2:0] idx;
      logic [7:0] code;
      logic [31:0] timer;
      logic [3:0] contact;
      logic speaker;
      logic standalone;
      logic [9:0] pulses;
   } disp_type;
   disp_type s_reg, s_next;
   logic [7:0] cur;
   always_comb
   begin
      s_next = s_reg;
      s_next.pulses = '0;
      cur = act.actions[8*s_reg.idx +: 8];
      case (s_reg.st)
         DISP_IDLE:
         begin
            s_next.idx = '0;
            if (act.req)
               s_next.st = DISP_FETCH;
         end
         DISP_FETCH:
         begin
            // codes taken strictly in list order
            s_next.code = cur;
            s_next.st = DISP_RUN;
         end
         DISP_RUN:
         begin
            s_next.st = DISP_FETCH;
            s_next.idx = s_reg.idx + 3'd1;
            if (s_reg.code == ACT_NOP)
               s_next.st = DISP_FETCH;
            else if (s_reg.code[7:4] == 4'h0 && s_reg.code[3:0] <= 4'h9)
               s_next.pulses[9] = 1'b1;
            else if (s_reg.code == ACT_SPEAKER)
               s_next.speaker = 1'b1;
            else if (s_reg.code[7:4] == 4'h1 && s_reg.code[3:0] <= 4'h9)
            begin
               s_next.speaker = 1'b1;
               s_next.timer = 32'(s_reg.code[3:0]) * 32'(SEC_CYCLES);
               s_next.st = DISP_WAIT;
            end
            else if (s_reg.code[7:4] == 4'h2 && s_reg.code[3:0] <= 4'h9)
               s_next.pulses[0] = 1'b1;
            else if (s_reg.code == ACT_CLOSE_ALL)
               s_next.contact = 4'hF;
            else if (s_reg.code[7:4] == 4'h3 && s_reg.code[3:0] < 4'h4)
               s_next.contact[s_reg.code[1:0]] = 1'b1;
            else if (s_reg.code == ACT_OPEN_ALL)
               s_next.contact = 4'h0;
            else if (s_reg.code[7:4] == 4'h4 && s_reg.code[3:0] < 4'h4)
               s_next.contact[s_reg.code[1:0]] = 1'b0;
            else if (s_reg.code == ACT_MODEM_INIT)
               s_next.pulses[1] = 1'b1;
            else if (s_reg.code == ACT_PANIC1)
               s_next.pulses[2] = 1'b1;
            else if (s_reg.code == ACT_PANIC2)
               s_next.pulses[3] = 1'b1;
            else if (s_reg.code == ACT_PANIC_LOG)
               s_next.pulses[4] = 1'b1;
            else if (s_reg.code == ACT_CNT_CLEAR)
               s_next.pulses[5] = 1'b1;
            else if (s_reg.code == ACT_LOG_EVENT)
               s_next.pulses[6] = 1'b1;
            else if (s_reg.code == ACT_STANDALONE)
               s_next.standalone = 1'b1;
            else if (s_reg.code == ACT_HOST_RESET)
               s_next.pulses[7] = 1'b1;
            // anything else falls through as a no-op
            if (s_reg.idx == 3'(ACT_PER_LIST - 1) && s_next.st != DISP_WAIT)
               s_next.st = DISP_IDLE;
         end
         DISP_WAIT:
         begin
            s_next.timer = s_reg.timer - 32'd1;
            if (s_reg.timer <= 32'd1)
            begin
               s_next.speaker = 1'b0;
               s_next.st = (s_reg.idx == 3'(ACT_PER_LIST - 1)) ?
                  DISP_IDLE : DISP_FETCH;
            end
         end
         default: s_next.st = DISP_IDLE;
      endcase
   end
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         s_reg <= '{st: DISP_IDLE, default: '0};
      else
         s_reg <= s_next;
   end
   assign act.ack = (s_reg.st == DISP_RUN || s_reg.st == DISP_WAIT) &&
      s_next.st == DISP_IDLE;
   assign act.cnt_clear = s_reg.pulses[5];
   assign contact = s_reg.contact;
   assign speaker = s_reg.speaker;
   assign console_req = s_reg.pulses[0];
   assign console_crlf = s_reg.code[3:0];
   assign modem_init = s_reg.pulses[1];
   assign panic_call1 = s_reg.pulses[2];
   assign panic_call2 = s_reg.pulses[3];
   assign panic_log = s_reg.pulses[4];
   assign event_log = s_reg.pulses[6];
   assign host_reset = s_reg.pulses[7];
   assign recheck_req = s_reg.pulses[9];
   assign recheck_min = s_reg.code[3:0];
   assign standalone = s_reg.standalone;

   standalone_sticky_a: assert property (@(posedge clk) disable iff (!nrst)
      $rose(s_reg.standalone) |=> s_reg.standalone[*8])
      else $error("standalone state left");
   host_reset_code_a: assert property (@(posedge clk) disable iff (!nrst)
      s_reg.pulses[7] |-> s_reg.code == ACT_HOST_RESET)
      else $error("host reset without code 99");
   close_all_a: assert property (@(posedge clk) disable iff (!nrst)
      s_reg.st == DISP_RUN && s_reg.code == ACT_CLOSE_ALL
      |=> contact == 4'hF)
      else $error("close all failed");
   open_all_a: assert property (@(posedge clk) disable iff (!nrst)
      s_reg.st == DISP_RUN && s_reg.code == ACT_OPEN_ALL
      |=> contact == 4'h0)
      else $error("open all failed");
   modem_code_a: assert property (@(posedge clk) disable iff (!nrst)
      modem_init |-> s_reg.code == ACT_MODEM_INIT)
      else $error("modem init without code 50");
   event_log_a: assert property (@(posedge clk) disable iff (!nrst)
      s_reg.st == DISP_RUN && s_reg.code == ACT_LOG_EVENT
      |=> event_log)
      else $error("log pulse missing");
endmodule
`default_nettype wire

// ==== verilog/event_action_monitor.sv ====
/*
 Event counters, sampling schedules, clear sources and threshold triggering.
 Assumes condition and command inputs come from pins (synchronised here);
 the action table arrives flattened on ports from configuration storage.
*/
//
// Operation
// - periodic conditions sampled every six seconds, counter updated.
// - heartbeat events checked once per configured heartbeat interval.
// - counters saturate at 9999, never above.
// - periodic counter clears once a sample shows the condition gone.
// - heartbeat message clears its event; a missing one counts.
// - all counters clear on commands, power-up, button held 3.5 s.
// - host bus reset clears all counters but increments counter 8.
// - clear-application-alarms clears only counters 13 through 28.
// - reaching a level threshold runs that level's actions: five, four if 11-19 is fourth, on past the list if it is fifth.
// - code 00 no-op; 01-09 delay recheck by that many minutes.
// - code 10 sounds speaker; 11-19 sound it for low-digit seconds.
// - codes 20-29 write console message after low-digit CRLF pairs.
// - codes 30-33 close one contact; 34 closes all four.
// - codes 40-43 open one contact; 44 opens all four.
// - code 50 reinitialises the modem, dropping the connection.
// - codes 51 and 52 place panic calls to numbers one, two.
// - code 53 appends a timestamped panic message to the buffer.
// - code 60 resets the counter of the executing event only.
// - code 70 logs event number, count and severity.
// - code 89 moves host-tracking to standalone; no effect otherwise.
// - code 99 reboots the host by hard reset.
// - list actions run strictly in listed order.
`timescale 1ns/100ps
`default_nettype none
module event_action_monitor
   import event_action_pkg::*;
#(
   parameter int SAMPLE_TICKS = SAMPLE_CYCLES,
   parameter int BUTTON_TICKS = BUTTON_CYCLES,
   parameter int MINUTE_TICKS = RECHECK_UNIT_S * SEC_CYCLES
)
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic [NUM_EVENTS-1:0] periodic_mask,
   input wire logic [NUM_EVENTS-1:0] heartbeat_mask,
   input wire logic [NUM_EVENTS-1:0] condition,
   input wire logic [NUM_EVENTS-1:0] episode_pulse,
   input wire logic [NUM_EVENTS-1:0] soft_clear,
   input wire logic [31:0] heartbeat_ticks,
   input wire logic heartbeat_msg,
   input wire logic clear_all_cmd,
   input wire logic clear_app_cmd,
   input wire logic bus_reset,
   input wire logic button,
   input wire logic [NUM_EVENTS*NUM_LEVELS*CNT_W-1:0] thresholds,
   input wire logic [NUM_EVENTS*NUM_LEVELS*8*ACT_PER_LIST-1:0] action_table,
   output logic [EVT_W-1:0] active_event,
   output logic [1:0] active_level,
   output logic [CNT_W-1:0] active_count,
   output logic [NUM_EVENTS*CNT_W-1:0] counters,
   output logic [3:0] contact,
   output logic speaker,
   output logic console_req,
   output logic [3:0] console_crlf,
   output logic modem_init,
   output logic panic_call1,
   output logic panic_call2,
   output logic panic_log,
   output logic event_log,
   output logic standalone,
   output logic host_reset
);
   initial
   begin
      if (SAMPLE_TICKS < 1 || BUTTON_TICKS < 1 || MINUTE_TICKS < 1)
         $error("tick counts must be at least one");
   end

   // ------------------------------------------------------------
   // input synchronisers
   // ------------------------------------------------------------
   localparam int SYNC_W = 4 * NUM_EVENTS + 5;
   logic [SYNC_W-1:0] raw, sync1_reg, sync2_reg;
   assign raw = {condition, episode_pulse, soft_clear, heartbeat_mask,
      heartbeat_msg, clear_all_cmd, clear_app_cmd, bus_reset, button};
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end
      else
      begin
         sync1_reg <= raw;
         sync2_reg <= sync1_reg;
      end
   end
   logic [NUM_EVENTS-1:0] cond_s, epi_s, sclr_s, hb_mask_s;
   logic hb_s, clr_all_s, clr_app_s, busrst_s, button_s;
   assign {cond_s, epi_s, sclr_s, hb_mask_s, hb_s, clr_all_s, clr_app_s,
      busrst_s, button_s} = sync2_reg;

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed
   {
      logic [NUM_EVENTS-1:0][CNT_W-1:0] cnt;
      logic [NUM_EVENTS-1:0][NUM_LEVELS-1:0] fired;
      logic [NUM_EVENTS-1:0] hold;
      logic [31:0] sample_tmr;
      logic [31:0] hb_tmr;
      logic [31:0] btn_tmr;
      logic [31:0] hold_tmr;
      logic hb_seen;
      logic epi_last_any;
      logic [NUM_EVENTS-1:0] epi_last;
      logic busrst_last;
      logic btn_done;
      logic req;
      logic [EVT_W-1:0] evt;
      logic [1:0] level;
      logic [CNT_W-1:0] count;
      logic [8*ACT_PER_LIST-1:0] actions;
   } mon_type;
   mon_type s_reg, s_next;

   action_if act ();
   logic [3:0] recheck_min;
   logic recheck_req;

   action_dispatch u_dispatch
   (
      .clk(clk),
      .nrst(nrst),
      .act(act.disp),
      .contact(contact),
      .speaker(speaker),
      .console_req(console_req),
      .console_crlf(console_crlf),
      .modem_init(modem_init),
      .panic_call1(panic_call1),
      .panic_call2(panic_call2),
      .panic_log(panic_log),
      .event_log(event_log),
      .standalone(standalone),
      .host_reset(host_reset),
      .recheck_min(recheck_min),
      .recheck_req(recheck_req)
   );
   assign act.req = s_reg.req;
   assign act.evt = s_reg.evt;
   assign act.level = s_reg.level;
   assign act.count = s_reg.count;
   assign act.actions = s_reg.actions;

   function automatic logic [CNT_W-1:0] bump(input logic [CNT_W-1:0] c);
      // saturate at the decimal ceiling
      bump = (c >= CNT_MAX) ? CNT_MAX : c + 14'h0001;
   endfunction

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   logic sample_tick, hb_tick, clr_all, busrst_rise;
   logic [CNT_W-1:0] th;
   always_comb
   begin
      s_next = s_reg;
      th = '0;
      sample_tick = (s_reg.sample_tmr == 32'd0);
      hb_tick = (s_reg.hb_tmr == 32'd0);
      busrst_rise = busrst_s && !s_reg.busrst_last;
      s_next.busrst_last = busrst_s;
      s_next.epi_last = epi_s;
      s_next.epi_last_any = |epi_s;
      s_next.sample_tmr = sample_tick ? 32'(SAMPLE_TICKS - 1) :
         s_reg.sample_tmr - 32'd1;
      s_next.hb_tmr = hb_tick ? heartbeat_ticks : s_reg.hb_tmr - 32'd1;
      // faceplate button counts only while held
      s_next.btn_tmr = button_s ? s_reg.btn_tmr + 32'd1 : 32'd0;
      s_next.btn_done = button_s && (s_reg.btn_done ||
         s_reg.btn_tmr >= 32'(BUTTON_TICKS));
      s_next.hb_seen = s_reg.hb_seen || hb_s;
      if (hb_tick)
         s_next.hb_seen = hb_s;
      // recheck hold, started by delay codes
      if (recheck_req)
      begin
         s_next.hold[act.evt] = 1'b1;
         s_next.hold_tmr = 32'(recheck_min) * 32'(MINUTE_TICKS);
      end
      else if (s_reg.hold_tmr != 32'd0)
         s_next.hold_tmr = s_reg.hold_tmr - 32'd1;
      else
         s_next.hold = '0;
      for (int e = 0; e < NUM_EVENTS; e++)
      begin
         if (s_reg.hold[e])
            continue;
         if (hb_mask_s[e])
         begin
            if (hb_tick)
               s_next.cnt[e] = s_reg.hb_seen ? CNT_RESET :
                  bump(s_reg.cnt[e]);
         end
         else if (periodic_mask[e])
         begin
            if (sample_tick)
               s_next.cnt[e] = cond_s[e] ? bump(s_reg.cnt[e]) :
                  CNT_RESET;
         end
         else if (epi_s[e] && !s_reg.epi_last[e])
            s_next.cnt[e] = bump(s_reg.cnt[e]);
         if (sclr_s[e])
            s_next.cnt[e] = CNT_RESET;
      end
      if (clr_app_s)
         for (int e = APP_FIRST_EVT; e <= APP_LAST_EVT; e++)
            s_next.cnt[e] = CNT_RESET;
      if (act.cnt_clear)
         s_next.cnt[act.evt] = CNT_RESET;
      clr_all = clr_all_s || (s_next.btn_done && !s_reg.btn_done);
      if (clr_all)
         s_next.cnt = '0;
      if (busrst_rise)
      begin
         for (int e = 0; e < NUM_EVENTS; e++)
            if (e != BUS_RESET_EVT)
               s_next.cnt[e] = CNT_RESET;
         s_next.cnt[BUS_RESET_EVT] = bump(s_reg.cnt[BUS_RESET_EVT]);
      end
      // threshold scan: first reached, not yet fired level
      for (int e = 0; e < NUM_EVENTS; e++)
         for (int l = 0; l < NUM_LEVELS; l++)
         begin
            th = thresholds[(e*NUM_LEVELS+l)*CNT_W +: CNT_W];
            if (s_reg.cnt[e] < th || th == CNT_RESET)
               s_next.fired[e][l] = 1'b0;
         end
      if (act.ack)
         s_next.req = 1'b0;
      if (!s_reg.req)
      begin
         for (int e = NUM_EVENTS - 1; e >= 0; e--)
            for (int l = NUM_LEVELS - 1; l >= 0; l--)
            begin
               th = thresholds[(e*NUM_LEVELS+l)*CNT_W +: CNT_W];
               if (th != CNT_RESET && s_reg.cnt[e] >= th &&
                  !s_reg.fired[e][l])
               begin
                  s_next.req = 1'b1;
                  s_next.evt = EVT_W'(e);
                  s_next.level = 2'(l);
                  s_next.count = s_reg.cnt[e];
                  s_next.actions = action_table[(e*NUM_LEVELS+l)*8*
                     ACT_PER_LIST +: 8*ACT_PER_LIST];
               end
            end
         if (s_next.req)
            s_next.fired[s_next.evt][s_next.level] = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         s_reg <= '0;
      else
         s_reg <= s_next;
   end

   assign active_event = s_reg.evt;
   assign active_level = s_reg.level;
   assign active_count = s_reg.count;
   assign counters = s_reg.cnt;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   for (genvar g = 0; g < NUM_EVENTS; g++)
   begin : g_chk
      cnt_ceiling_a: assert property (@(posedge clk) disable iff (!nrst)
         s_reg.cnt[g] <= CNT_MAX)
         else $error("counter above 9999");
   end
   clear_all_a: assert property (@(posedge clk) disable iff (!nrst)
      clr_all_s && !busrst_rise |=> s_reg.cnt == '0)
      else $error("clear all missed");
   bus_reset_evt_a: assert property (@(posedge clk) disable iff (!nrst)
      busrst_rise && s_reg.cnt[BUS_RESET_EVT] < CNT_MAX
      |=> s_reg.cnt[BUS_RESET_EVT] != CNT_RESET)
      else $error("bus reset not counted");
   periodic_clear_a: assert property (@(posedge clk) disable iff (!nrst)
      sample_tick && periodic_mask[2] && !hb_mask_s[2] && !cond_s[2] &&
      !s_reg.hold[2] |=> s_reg.cnt[2] == CNT_RESET)
      else $error("periodic counter kept");
   soft_clear_a: assert property (
      @(posedge clk) disable iff (!nrst)
      sclr_s[9] && !busrst_rise |=> s_reg.cnt[9] == CNT_RESET)
      else $error("soft clear missed");
   app_clear_a: assert property (
      @(posedge clk) disable iff (!nrst)
      clr_app_s |=> s_reg.cnt[13] == CNT_RESET && s_reg.cnt[28] == CNT_RESET)
      else $error("application clear missed");
   bus_reset_clear_a: assert property (
      @(posedge clk) disable iff (!nrst)
      busrst_rise |=> s_reg.cnt[9] == CNT_RESET)
      else $error("bus reset did not clear");
   hb_clear_a: assert property (
      @(posedge clk) disable iff (!nrst)
      hb_tick && hb_mask_s[6] && s_reg.hb_seen && !s_reg.hold[6]
      |=> s_reg.cnt[6] == CNT_RESET)
      else $error("heartbeat did not clear");
   hb_miss_a: assert property (
      @(posedge clk) disable iff (!nrst)
      hb_tick && hb_mask_s[6] && !s_reg.hb_seen && !s_reg.hold[6] &&
      !clr_all && !sclr_s[6] && !busrst_rise && !act.cnt_clear
      |=> s_reg.cnt[6] != CNT_RESET)
      else $error("missing heartbeat not counted");
   sample_period_a: assert property (
      @(posedge clk) disable iff (!nrst)
      sample_tick |=> s_reg.sample_tmr == 32'(SAMPLE_TICKS - 1))
      else $error("sample period wrong");
   hb_interval_a: assert property (
      @(posedge clk) disable iff (!nrst)
      hb_tick |=> s_reg.hb_tmr == $past(heartbeat_ticks))
      else $error("heartbeat interval wrong");
   button_clear_a: assert property (
      @(posedge clk) disable iff (!nrst)
      s_next.btn_done && !s_reg.btn_done && !busrst_rise
      |=> s_reg.cnt == '0)
      else $error("button clear missed");
   req_hold_a: assert property (
      @(posedge clk) disable iff (!nrst)
      s_reg.req && !act.ack |=> s_reg.req)
      else $error("trigger dropped before ack");
   fired_mark_a: assert property (
      @(posedge clk) disable iff (!nrst)
      $rose(s_reg.req) |-> s_reg.fired[s_reg.evt][s_reg.level])
      else $error("trigger not marked fired");
   own_clear_a: assert property (
      @(posedge clk) disable iff (!nrst)
      act.cnt_clear && act.evt == 6'h0D |=> s_reg.cnt[13] == CNT_RESET)
      else $error("own counter not cleared");
   recheck_hold_a: assert property (
      @(posedge clk) disable iff (!nrst)
      recheck_req |=> s_reg.hold != '0)
      else $error("recheck hold not started");
endmodule
`default_nettype wire

// ==== bench/host_model.sv ====
/*
 Host platform model: heartbeat messages and a bus reset after hard reset.
 Assumes the bench clock; its outputs change at the falling edge.
*/
`timescale 1ns/100ps
`default_nettype none
module host_model
(
   input wire logic clk,
   input wire logic alive,
   input wire logic host_reset,
   output logic heartbeat_msg,
   output logic bus_reset
);
   int hb_cnt = 0;
   int boot_cnt = 0;
   initial heartbeat_msg = 1'b0;
   initial bus_reset = 1'b0;
   // ------------------------------
   // heartbeat and reboot
   // ------------------------------
   always @(negedge clk)
   begin
      hb_cnt = (hb_cnt + 1) % 10;
      heartbeat_msg <= alive && hb_cnt == 0;
      // a rebooting host shows its bus reset some time later
      if (host_reset)
         boot_cnt = 30;
      else if (boot_cnt > 0)
         boot_cnt = boot_cnt - 1;
      bus_reset <= boot_cnt inside {[1:8]};
   end
endmodule
`default_nettype wire

// ==== bench/tb.sv ====
/*
 Self-checking bench of the event monitor, with a host model.
 Assumes shortened tick parameters; inputs change at the falling edge.
*/
`timescale 1ns/100ps
`default_nettype none
module tb;
   import event_action_pkg::*;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [NUM_EVENTS-1:0] pmask = '0, hmask = '0, cond = '0, epi = '0;
   logic [NUM_EVENTS-1:0] sclr = '0;
   logic clr_all = 1'b0, clr_app = 1'b0, button = 1'b0, alive = 1'b1;
   logic [NUM_EVENTS*NUM_LEVELS*CNT_W-1:0] thr = '0;
   logic [NUM_EVENTS*NUM_LEVELS*8*ACT_PER_LIST-1:0] acts = '0;
   logic [NUM_EVENTS*CNT_W-1:0] counters;
   logic [3:0] contact, crlf;
   logic speaker, con, modem, p1, p2, plog, elog, sa, hrst, hb, brst;
   logic [7:0] expq[$];
   logic [7:0] obs;
   logic [3:0] last_ct = 4'h0;
   logic last_sa = 1'b0, last_sp = 1'b0;
   int n_mismatch = 0;
   int checks = 0;
   int n;
   event_action_monitor #(.SAMPLE_TICKS(20), .BUTTON_TICKS(10),
      .MINUTE_TICKS(5)) dut_u (.clk(clk), .nrst(nrst),
      .periodic_mask(pmask), .heartbeat_mask(hmask), .condition(cond),
      .episode_pulse(epi), .soft_clear(sclr), .heartbeat_ticks(32'h28),
      .heartbeat_msg(hb), .clear_all_cmd(clr_all), .clear_app_cmd(clr_app),
      .bus_reset(brst), .button(button), .thresholds(thr),
      .action_table(acts), .active_event(), .active_level(),
      .active_count(), .counters(counters), .contact(contact),
      .speaker(speaker), .console_req(con), .console_crlf(crlf),
      .modem_init(modem), .panic_call1(p1), .panic_call2(p2),
      .panic_log(plog), .event_log(elog), .standalone(sa),
      .host_reset(hrst));
   host_model host_u (.clk(clk), .alive(alive), .host_reset(hrst),
      .heartbeat_msg(hb), .bus_reset(brst));
   initial forever #25 clk = ~clk;
   // ------------------------------
   // helpers
   // ------------------------------
   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   function automatic logic [CNT_W-1:0] cnt(int e);
      return counters[e*CNT_W +: CNT_W];
   endfunction
   // bounded wait; the compare fails only if the value has not arrived within 200 cycles
   task automatic wait_cnt(int e, logic [CNT_W-1:0] v);
      for (int i = 0; i < 200 && cnt(e) !== v; i++)
         @(negedge clk);
      chk("counter", {18'h0, v}, {18'h0, cnt(e)});
   endtask
   task automatic pulse(int e);
      epi[e] = 1'b1;
      repeat (4) @(negedge clk);
      epi[e] = 1'b0;
      repeat (4) @(negedge clk);
   endtask
   task automatic set_list(int e, int l, logic [CNT_W-1:0] t,
      logic [39:0] a);
      thr[(e*3+l)*CNT_W +: CNT_W] = t;
      acts[(e*3+l)*40 +: 40] = a;
   endtask
   task automatic tally_and_finish;
      if (n_mismatch == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // ------------------------------
   // action watcher
   // ------------------------------
   always @(negedge clk)
   begin
      obs = elog ? 8'h70 : con ? {4'h2, crlf} : modem ? 8'h50 :
         p1 ? 8'h51 : p2 ? 8'h52 : plog ? 8'h53 : hrst ? 8'h99 :
         contact !== last_ct ? {4'hC, contact} :
         (sa && !last_sa) ? 8'h89 : (speaker && !last_sp) ? 8'h10 : 8'h00;
      if (nrst && obs !== 8'h00)
      begin
         if (expq.size() == 0)
            chk("spurious action", 32'h0, {24'h0, obs});
         else
            chk("action", {24'h0, expq.pop_front()}, {24'h0, obs});
      end
      last_ct = contact;
      last_sa = sa;
      last_sp = speaker;
   end
   initial
   begin
      #2000000;
      n_mismatch++;
      tally_and_finish;
   end
   // ------------------------------
   // scenarios
   // ------------------------------
   initial
   begin
      void'($urandom(61));
      hmask[6] = 1'b1;
      pmask[2] = 1'b1;
      set_list(13, 0, 14'h0002, 40'h5352512570);
      set_list(13, 1, 14'h0003, 40'h9960895034);
      set_list(14, 0, 14'h0001, 40'h00021043AB);
      repeat (16) @(posedge clk);
      @(negedge clk);
      nrst = 1'b1;
      cond[2] = 1'b1;
      wait_cnt(2, 14'h0001);
      for (n = 0; n < 100 && cnt(2) !== 14'h0002; n++)
         @(negedge clk);
      chk("sample period", 32'h14, n);
      cond[2] = 1'b0;
      wait_cnt(2, 14'h0000);
      repeat (100) @(negedge clk);
      chk("heartbeat count", 32'h0, {18'h0, cnt(6)});
      alive = 1'b0;
      wait_cnt(6, 14'h0002);
      alive = 1'b1;
      wait_cnt(6, 14'h0000);
      n = $urandom_range(6, 3);
      repeat (n) pulse(20);
      pulse(9);
      wait_cnt(20, n[13:0]);
      clr_app = 1'b1;
      repeat (4) @(negedge clk);
      clr_app = 1'b0;
      wait_cnt(20, 14'h0000);
      chk("outside app range", 32'h1, {18'h0, cnt(9)});
      sclr[9] = 1'b1;
      repeat (4) @(negedge clk);
      sclr[9] = 1'b0;
      wait_cnt(9, 14'h0000);
      pulse(9);
      button = 1'b1;
      repeat (15) @(negedge clk);
      button = 1'b0;
      wait_cnt(9, 14'h0000);
      pulse(9);
      clr_all = 1'b1;
      repeat (4) @(negedge clk);
      clr_all = 1'b0;
      wait_cnt(9, 14'h0000);
      expq = '{8'h70, 8'h25, 8'h51, 8'h52, 8'h53, 8'hCF, 8'h50, 8'h89,
         8'h99, 8'hC7, 8'h10};
      pulse(9);
      repeat (3) pulse(13);
      wait_cnt(13, 14'h0000);
      chk("other counter", 32'h1, {18'h0, cnt(9)});
      wait_cnt(8, 14'h0001);
      chk("after bus reset", 32'h0, {18'h0, cnt(9)});
      pulse(14);
      repeat (30) @(negedge clk);
      chk("actions left", 32'h0, expq.size());
      tally_and_finish;
   end
endmodule
`default_nettype wire
